// File: hw/bsrc_map.vh
// Purpose: constants of the boundary scan test data register block
// Assumes: 10 MHz system clock samples the test clock pins
// Notes: chain bit 0 is nearest the serial output
`ifndef BSRC_MAP_VH
`define BSRC_MAP_VH

// ==========================================
// instruction register
`define BSRC_IR_W 6
`define BSRC_IR_EXTEST 6'h00
`define BSRC_IR_SAMPLE 6'h01
`define BSRC_IR_IDCODE 6'h02
`define BSRC_IR_HIGHZ 6'h03
`define BSRC_IR_CAPTURE 6'h2d
`define BSRC_IR_CLAMP 6'h3e
`define BSRC_IR_BYPASS 6'h3f

// ==========================================
// boundary chain layout
`define BSRC_N_RX 10
`define BSRC_N_OBS 25
`define BSRC_N_TX 5
`define BSRC_N_BIDI 16
`define BSRC_TX_BASE 25
`define BSRC_BIDI_BASE 30
`define BSRC_CHAIN_W 62
`define BSRC_ID_W 32

// ==========================================
// pin sampling and buffering
`define BSRC_SYNC_STAGES 3
`define BSRC_N_SYNC 45
`define BSRC_FIFO_DEPTH 16
`define BSRC_TCK_PERIOD_NS 800
`define BSRC_CLK_PERIOD_NS 100

`endif

// File: hw/bsrc_fifo.v
// Purpose: snapshot buffer with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: full and empty are exact; no write when full
module bsrc_fifo #(
   parameter WIDTH = 62,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clock,
   input wire srst,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output reg [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_r;
   reg [AW:0] rd_r;
   wire push;
   wire pop;
   wire [AW:0] used;

   assign used = wr_r - rd_r;
   assign in_ready = (used != DEPTH[AW:0]);
   assign out_valid = (used != {(AW+1){1'b0}});
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge clock) begin
      if (push) begin
         mem[wr_r[AW-1:0]] <= in_data;
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         wr_r <= {(AW+1){1'b0}};
         rd_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_r <= wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= rd_r + 1'b1;
         end
      end
   end

   always @* begin
      out_data = mem[rd_r[AW-1:0]];
   end
endmodule

// File: hw/bsrc_chain.v
// Purpose: tap controller, boundary, bypass and identification registers
// Assumes: test pins sampled by the 10 MHz clock, tck well below clock/6
// Notes: bidir index 0..3 smbus clk/dat master then slave, 4..14 gpio, 15 wake
`include "bsrc_map.vh"
module bsrc_chain #(
   parameter [`BSRC_ID_W-1:0] ID_VALUE = 32'h00000001, // arbitrary value
   parameter FIFO_DEPTH = `BSRC_FIFO_DEPTH
) (
   input wire clock,
   input wire srst,
   input wire jtag_tck,
   input wire jtag_tms,
   input wire jtag_tdi,
   input wire jtag_trst_n,
   output reg jtag_tdo_out,
   output reg jtag_tdo_oe,
   input wire [`BSRC_N_RX-1:0] rx_lane_pin,
   input wire refclk_mode_select,
   input wire [3:0] master_smbus_addr_strap,
   input wire [3:0] slave_smbus_addr_strap,
   input wire auto_power_disable_n,
   input wire downstream_common_clock,
   input wire upstream_common_clock,
   input wire master_smbus_speed_sel,
   input wire fundamental_reset_n,
   input wire reset_halt_strap,
   input wire [`BSRC_N_TX-1:0] core_tx_data,
   output reg [`BSRC_N_TX-1:0] tx_lane_out,
   input wire [`BSRC_N_BIDI-1:0] core_pad_out,
   input wire [`BSRC_N_BIDI-1:0] core_pad_oe,
   input wire [`BSRC_N_BIDI-1:0] pad_in,
   output reg [`BSRC_N_BIDI-1:0] pad_out,
   output reg [`BSRC_N_BIDI-1:0] pad_oe,
   output wire [`BSRC_CHAIN_W-1:0] snap_data,
   output wire snap_valid,
   input wire snap_ready,
   output wire snap_in_ready
);
   localparam [3:0] ST_TLR = 4'h0;
   localparam [3:0] ST_RTI = 4'h1;
   localparam [3:0] ST_SEL_DR = 4'h2;
   localparam [3:0] ST_CAP_DR = 4'h3;
   localparam [3:0] ST_SH_DR = 4'h4;
   localparam [3:0] ST_EX1_DR = 4'h5;
   localparam [3:0] ST_PA_DR = 4'h6;
   localparam [3:0] ST_EX2_DR = 4'h7;
   localparam [3:0] ST_UPD_DR = 4'h8;
   localparam [3:0] ST_SEL_IR = 4'h9;
   localparam [3:0] ST_CAP_IR = 4'ha;
   localparam [3:0] ST_SH_IR = 4'hb;
   localparam [3:0] ST_EX1_IR = 4'hc;
   localparam [3:0] ST_PA_IR = 4'hd;
   localparam [3:0] ST_EX2_IR = 4'he;
   localparam [3:0] ST_UPD_IR = 4'hf;
   localparam NS = `BSRC_N_SYNC;
   localparam CW = `BSRC_CHAIN_W;

   // ==========================================
   // decode helpers
   function [3:0] tap_next;
      input [3:0] st;
      input tms;
      begin
         case (st)
            ST_TLR: tap_next = tms ? ST_TLR : ST_RTI;
            ST_RTI: tap_next = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_next = tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR: tap_next = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: tap_next = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: tap_next = tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tap_next = tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR: tap_next = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: tap_next = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_RTI;
            default: tap_next = ST_TLR;
         endcase
      end
   endfunction

   // boundary chain selected by either of the two boundary codes
   function sel_boundary;
      input [`BSRC_IR_W-1:0] ir;
      begin
         sel_boundary = (ir == `BSRC_IR_EXTEST) || (ir == `BSRC_IR_SAMPLE);
      end
   endfunction

   function sel_ident;
      input [`BSRC_IR_W-1:0] ir;
      begin
         sel_ident = (ir == `BSRC_IR_IDCODE);
      end
   endfunction

   // ==========================================
   // pin sampling: three flops, change taken when stages two and three agree
   wire [NS-1:0] raw_w;
   reg [NS-1:0] s1_r;
   reg [NS-1:0] s2_r;
   reg [NS-1:0] s3_r;
   reg [NS-1:0] filt_r;
   reg tck_prev_r;

   assign raw_w = {pad_in, reset_halt_strap, fundamental_reset_n, master_smbus_speed_sel,
                   upstream_common_clock, downstream_common_clock, auto_power_disable_n,
                   slave_smbus_addr_strap, master_smbus_addr_strap, refclk_mode_select,
                   rx_lane_pin, jtag_trst_n, jtag_tdi, jtag_tms, jtag_tck};

   always @(posedge clock) begin
      if (srst) begin
         s1_r <= {NS{1'b0}};
         s2_r <= {NS{1'b0}};
         s3_r <= {NS{1'b0}};
         filt_r <= {NS{1'b0}};
         tck_prev_r <= 1'b0;
      end else begin
         s1_r <= raw_w;
         s2_r <= s1_r;
         s3_r <= s2_r;
         filt_r <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
         tck_prev_r <= filt_r[0];
      end
   end

   wire tck_rise = filt_r[0] & ~tck_prev_r;
   wire tck_fall = ~filt_r[0] & tck_prev_r;
   wire tms_f = filt_r[1];
   wire tdi_f = filt_r[2];
   wire trst_f = ~filt_r[3];
   wire [`BSRC_N_OBS-1:0] obs_f = filt_r[4 +: `BSRC_N_OBS];
   wire [`BSRC_N_BIDI-1:0] pad_f = filt_r[4 + `BSRC_N_OBS +: `BSRC_N_BIDI];

   // ==========================================
   // tap controller
   reg [3:0] state_r;
   reg [3:0] state_nxt;

   always @* begin
      state_nxt = state_r;
      if (tck_rise) begin
         state_nxt = tap_next(state_r, tms_f);
      end
   end

   always @(posedge clock) begin
      if (srst || trst_f) begin
         state_r <= ST_TLR;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ==========================================
   // instruction register
   reg [`BSRC_IR_W-1:0] ir_sh_r;
   reg [`BSRC_IR_W-1:0] ir_r;

   always @(posedge clock) begin
      if (srst || trst_f || state_r == ST_TLR) begin
         ir_sh_r <= `BSRC_IR_IDCODE;
         ir_r <= `BSRC_IR_IDCODE;
      end else begin
         if (tck_rise && state_r == ST_CAP_IR) begin
            ir_sh_r <= `BSRC_IR_CAPTURE;
         end else if (tck_rise && state_r == ST_SH_IR) begin
            ir_sh_r <= {tdi_f, ir_sh_r[`BSRC_IR_W-1:1]};
         end
         if (tck_fall && state_r == ST_UPD_IR) begin
            ir_r <= ir_sh_r;
         end
      end
   end

   wire extest_w = (ir_r == `BSRC_IR_EXTEST);
   wire clamp_w = (ir_r == `BSRC_IR_CLAMP);
   wire highz_w = (ir_r == `BSRC_IR_HIGHZ);
   wire pins_held_w = extest_w | clamp_w;

   // ==========================================
   // capture word: observe, tx data, then enable/capture pairs
   wire [CW-1:0] cap_w;

   assign cap_w[`BSRC_N_OBS-1:0] = obs_f;
   assign cap_w[`BSRC_TX_BASE +: `BSRC_N_TX] = core_tx_data;

   genvar gi;
   generate
      for (gi = 0; gi < `BSRC_N_BIDI; gi = gi + 1) begin : g_bidi
         // enable cell samples the core's enable like an output cell
         assign cap_w[`BSRC_BIDI_BASE + 2 * gi] = core_pad_oe[gi];
         // single capture register, mux steered by enable outside external test
         assign cap_w[`BSRC_BIDI_BASE + 2 * gi + 1] =
            (~extest_w & core_pad_oe[gi]) ? core_pad_out[gi] : pad_f[gi];
      end
   endgenerate

   // ==========================================
   // test data registers in parallel
   reg [CW-1:0] bs_sh_r;
   reg byp_r;
   reg [`BSRC_ID_W-1:0] id_sh_r;
   reg [`BSRC_N_TX-1:0] upd_tx_r;
   reg [`BSRC_N_BIDI-1:0] upd_oe_r;
   wire bs_sel_w = sel_boundary(ir_r);
   wire id_sel_w = sel_ident(ir_r);
   wire [`BSRC_N_BIDI-1:0] sh_oe_w;

   generate
      for (gi = 0; gi < `BSRC_N_BIDI; gi = gi + 1) begin : g_oe
         assign sh_oe_w[gi] = bs_sh_r[`BSRC_BIDI_BASE + 2 * gi];
      end
   endgenerate

   always @(posedge clock) begin
      if (srst || trst_f) begin
         bs_sh_r <= {CW{1'b0}};
         byp_r <= 1'b0;
         id_sh_r <= {`BSRC_ID_W{1'b0}};
      end else if (tck_rise) begin
         if (state_r == ST_CAP_DR) begin
            byp_r <= 1'b0;
            id_sh_r <= ID_VALUE;
            if (bs_sel_w) begin
               bs_sh_r <= cap_w;
            end
         end else if (state_r == ST_SH_DR) begin
            // every register sees the same serial input
            byp_r <= tdi_f;
            id_sh_r <= {tdi_f, id_sh_r[`BSRC_ID_W-1:1]};
            if (bs_sel_w) begin
               bs_sh_r <= {tdi_f, bs_sh_r[CW-1:1]};
            end
         end
      end
   end

   // update latches move on the falling edge of update-dr only
   always @(posedge clock) begin
      if (srst || trst_f) begin
         upd_tx_r <= {`BSRC_N_TX{1'b0}};
         upd_oe_r <= {`BSRC_N_BIDI{1'b0}};
      end else if (tck_fall && state_r == ST_UPD_DR && bs_sel_w) begin
         upd_tx_r <= bs_sh_r[`BSRC_TX_BASE +: `BSRC_N_TX];
         upd_oe_r <= sh_oe_w;
      end
   end

   // ==========================================
   // serial output, changed on falling test clock
   reg tdo_src_w;

   always @* begin
      if (state_r == ST_SH_IR) begin
         tdo_src_w = ir_sh_r[0];
      end else if (bs_sel_w) begin
         tdo_src_w = bs_sh_r[0];
      end else if (id_sel_w) begin
         tdo_src_w = id_sh_r[0];
      end else begin
         tdo_src_w = byp_r;
      end
   end

   always @(posedge clock) begin
      if (srst || trst_f) begin
         jtag_tdo_out <= 1'b0;
         jtag_tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         jtag_tdo_oe <= (state_r == ST_SH_DR) || (state_r == ST_SH_IR);
         jtag_tdo_out <= ((state_r == ST_SH_DR) || (state_r == ST_SH_IR)) & tdo_src_w;
      end
   end

   // ==========================================
   // pin drive: tx and enable latches under external test or clamp, enables off under highz, core otherwise; pad data always from core
   always @(posedge clock) begin
      if (srst) begin
         tx_lane_out <= {`BSRC_N_TX{1'b0}};
         pad_out <= {`BSRC_N_BIDI{1'b0}};
         pad_oe <= {`BSRC_N_BIDI{1'b0}};
      end else begin
         tx_lane_out <= pins_held_w ? upd_tx_r : core_tx_data;
         pad_out <= core_pad_out;
         if (pins_held_w) begin
            pad_oe <= upd_oe_r;
         end else if (highz_w) begin
            pad_oe <= {`BSRC_N_BIDI{1'b0}};
         end else begin
            pad_oe <= core_pad_oe;
         end
      end
   end

   // ==========================================
   // boundary snapshots logged at each capture-dr under extest or sample while the buffer has room
   bsrc_fifo #(
      .WIDTH(CW),
      .DEPTH(FIFO_DEPTH),
      .AW(4)
   ) u_snap (
      .clock(clock),
      .srst(srst),
      .in_valid(tck_rise && state_r == ST_CAP_DR && bs_sel_w),
      .in_ready(snap_in_ready),
      .in_data(cap_w),
      .out_valid(snap_valid),
      .out_ready(snap_ready),
      .out_data(snap_data)
   );
endmodule

// File: tb/bsrc_chain_props.sv
// Purpose: port-level checks of the boundary scan register block
// Assumes: test clock pin moves far slower than the system clock
// Notes: quiet_r counts system clocks since the last test clock fall or trst
module bsrc_chain_props (
   input wire logic clock,
   input wire logic srst,
   input wire logic jtag_tck,
   input wire logic jtag_trst_n,
   input wire logic jtag_tdo_oe,
   input wire logic [4:0] core_tx_data,
   input wire logic [4:0] tx_lane_out,
   input wire logic [15:0] core_pad_out,
   input wire logic [15:0] core_pad_oe,
   input wire logic [15:0] pad_out,
   input wire logic [15:0] pad_oe,
   input wire logic [61:0] snap_data,
   input wire logic snap_valid,
   input wire logic snap_ready,
   input wire logic snap_in_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   logic tck_d_r;
   logic [3:0] quiet_r;
   always @(posedge clock) begin
      tck_d_r <= jtag_tck;
      if (srst || !jtag_trst_n || (tck_d_r && !jtag_tck))
         quiet_r <= 4'h0;
      else if (quiet_r != 4'hf)
         quiet_r <= quiet_r + 4'h1;
   end
   // ==========================================
   // assertions
   a_reset_quiet: assert property (@(posedge clock) disable iff (1'b0)
      srst |=> pad_oe == 16'h0 && !jtag_tdo_oe) else $error("outputs live after reset");
   a_trst_pins: assert property (!jtag_trst_n [*6] |=>
      pad_oe == $past(core_pad_oe) && tx_lane_out == $past(core_tx_data))
      else $error("pins ignore core under test reset");
   a_trst_tdo: assert property (!jtag_trst_n [*6] |=> !jtag_tdo_oe)
      else $error("serial out driven under test reset");
   a_oe_quiet: assert property (quiet_r == 4'hf && $changed(pad_oe) |->
      $past(core_pad_oe) != $past(core_pad_oe, 2)) else $error("enable moved without cause");
   a_tx_quiet: assert property (quiet_r == 4'hf && $changed(tx_lane_out) |->
      $past(core_tx_data) != $past(core_tx_data, 2)) else $error("tx pin moved without cause");
   a_pad_follow: assert property (!$past(srst) && !$past(srst, 2) |->
      pad_out == $past(core_pad_out)) else $error("pad data not from core");
   a_snap_hold: assert property (snap_valid && !snap_ready |=>
      snap_valid && $stable(snap_data)) else $error("snapshot dropped while stalled");
   a_snap_pop: assert property (!$past(srst) && $fell(snap_valid) |->
      $past(snap_ready)) else $error("snapshot lost without pop");
   a_full_valid: assert property (!snap_in_ready |-> snap_valid)
      else $error("full buffer shows no data");
   c_tdo_on: cover property ($rose(jtag_tdo_oe));
   c_full: cover property ($fell(snap_in_ready));
   c_follow: cover property (quiet_r == 4'hf && $changed(pad_oe));
endmodule

bind bsrc_chain bsrc_chain_props u_props (.clock(clock), .srst(srst), .jtag_tck(jtag_tck),
   .jtag_trst_n(jtag_trst_n), .jtag_tdo_oe(jtag_tdo_oe), .core_tx_data(core_tx_data),
   .tx_lane_out(tx_lane_out), .core_pad_out(core_pad_out), .core_pad_oe(core_pad_oe),
   .pad_out(pad_out), .pad_oe(pad_oe), .snap_data(snap_data), .snap_valid(snap_valid),
   .snap_ready(snap_ready), .snap_in_ready(snap_in_ready));

// File: tb/bsrc_tester.sv
// Purpose: board tester model driving the test access pins
// Assumes: one test clock period is eight system clocks
// Notes: test clock parks low between scans; data in idles high like its pull-up
module bsrc_tester (
   input wire logic clock,
   input wire logic jtag_tdo_out,
   output logic jtag_tck,
   output logic jtag_tms,
   output logic jtag_tdi,
   output logic jtag_trst_n
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      jtag_tck = 1'b0;
      jtag_tms = 1'b1;
      jtag_tdi = 1'b1;
      jtag_trst_n = 1'b1;
   end
   // ==========================================
   // one test clock period, serial out read late in the high phase
   task automatic tick(input logic t, input logic d, output logic o);
      repeat (2) @(posedge clock);
      jtag_tms <= t;
      jtag_tdi <= d;
      repeat (2) @(posedge clock);
      jtag_tck <= 1'b1;
      repeat (3) @(posedge clock);
      @(negedge clock);
      o = jtag_tdo_out;
      @(posedge clock);
      jtag_tck <= 1'b0;
   endtask
   // from idle through capture, shift and update back to idle
   task automatic scan(input logic ir, input int n, input logic [61:0] din,
      output logic [61:0] dout);
      logic o;
      dout = '0;
      tick(1'b1, 1'b1, o);
      if (ir)
         tick(1'b1, 1'b1, o);
      tick(1'b0, 1'b1, o);
      tick(1'b0, 1'b1, o);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], o);
         dout[i] = o;
      end
      tick(1'b1, 1'b1, o);
      tick(1'b0, 1'b1, o);
      @(negedge clock);
   endtask
   task automatic shift_ir(input logic [5:0] code);
      logic [61:0] o;
      scan(1'b1, 6, 62'(code), o);
   endtask
   task automatic reset_tap();
      logic o;
      repeat (5) tick(1'b1, 1'b1, o);
      tick(1'b0, 1'b1, o);
   endtask
   task automatic hold_trst(input int n);
      @(posedge clock);
      jtag_trst_n <= 1'b0;
      repeat (n) @(posedge clock);
      jtag_trst_n <= 1'b1;
   endtask
endmodule

// File: tb/bsrc_chain_tb.sv
// Purpose: self-checking bench of the boundary scan register block
// Assumes: tester model owns the test access pins
// Notes: only observe and bidir capture bits of a capture word are judged
`include "bsrc_map.vh"
module bsrc_chain_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] ID = 32'h00005a17; // arbitrary value
   localparam logic [61:0] MASK = {{16{2'b10}}, 5'h00, 25'h1ffffff};
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic tck, tms, tdi, trst_n, tdo_out, tdo_oe;
   logic [9:0] rx = 10'h2b5;
   logic refm = 1'b1;
   logic [3:0] maddr = 4'h9;
   logic [3:0] saddr = 4'h6;
   logic [5:0] sys = 6'h16;
   logic [4:0] ctx = 5'h0c;
   logic [4:0] tx_out;
   logic [15:0] cpo = 16'h0ff0;
   logic [15:0] coe = 16'h5a5a;
   logic [15:0] pin = 16'h33cc;
   logic [15:0] pout, poe;
   logic [61:0] snap, d;
   logic snap_valid, snap_in_ready;
   logic snap_ready = 1'b0;
   int n_mismatch = 0;
   int n_tests = 0;
   always #50 clock = ~clock;
   bsrc_chain #(.ID_VALUE(ID), .FIFO_DEPTH(16)) DUT (.clock(clock), .srst(srst),
      .jtag_tck(tck), .jtag_tms(tms), .jtag_tdi(tdi), .jtag_trst_n(trst_n),
      .jtag_tdo_out(tdo_out), .jtag_tdo_oe(tdo_oe), .rx_lane_pin(rx),
      .refclk_mode_select(refm), .master_smbus_addr_strap(maddr),
      .slave_smbus_addr_strap(saddr), .auto_power_disable_n(sys[0]),
      .downstream_common_clock(sys[1]), .upstream_common_clock(sys[2]),
      .master_smbus_speed_sel(sys[3]), .fundamental_reset_n(sys[4]),
      .reset_halt_strap(sys[5]), .core_tx_data(ctx), .tx_lane_out(tx_out),
      .core_pad_out(cpo), .core_pad_oe(coe), .pad_in(pin), .pad_out(pout), .pad_oe(poe),
      .snap_data(snap), .snap_valid(snap_valid), .snap_ready(snap_ready),
      .snap_in_ready(snap_in_ready));
   bsrc_tester tester (.clock(clock), .jtag_tdo_out(tdo_out), .jtag_tck(tck),
      .jtag_tms(tms), .jtag_tdi(tdi), .jtag_trst_n(trst_n));
   // ==========================================
   // helpers
   task automatic cmp(input string what, input logic [61:0] exp, input logic [61:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [61:0] mk(input logic [4:0] tx, input logic [15:0] oe);
      logic [61:0] w;
      w = '0;
      w[29:25] = tx;
      for (int i = 0; i < 16; i++)
         w[30+2*i] = oe[i];
      return w;
   endfunction
   function automatic logic [61:0] exp_cap(input logic ext);
      logic [61:0] w;
      w = 62'({sys, saddr, maddr, refm, rx});
      for (int i = 0; i < 16; i++)
         w[31+2*i] = (coe[i] && !ext) ? cpo[i] : pin[i];
      return w;
   endfunction
   task automatic pop();
      @(posedge clock);
      snap_ready <= 1'b1;
      @(posedge clock);
      snap_ready <= 1'b0;
      @(negedge clock);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ==========================================
   // scenarios
   task automatic t_idcode();
      tester.reset_tap();
      tester.scan(1'b0, 32, '1, d);
      cmp("idcode", 62'(ID), 62'(d[31:0]));
      cmp("tdo enable", 62'h0, 62'(tdo_oe));
   endtask
   task automatic t_bypass();
      tester.shift_ir(`BSRC_IR_BYPASS);
      tester.scan(1'b0, 8, 62'h35, d);
      cmp("bypass", 62'h6a, 62'(d[7:0]));
   endtask
   task automatic t_sample();
      tester.shift_ir(`BSRC_IR_SAMPLE);
      tester.scan(1'b0, 62, mk(5'h15, 16'hc3a5), d);
      cmp("sample word", exp_cap(1'b0), d & MASK);
      cmp("snapshot", exp_cap(1'b0), snap & MASK);
      cmp("snap valid", 62'h1, 62'(snap_valid));
      cmp("oe in sample", 62'(coe), 62'(poe));
      cmp("tx in sample", 62'(ctx), 62'(tx_out));
      pop();
   endtask
   task automatic t_extest();
      tester.shift_ir(`BSRC_IR_EXTEST);
      cmp("tx update", 62'h15, 62'(tx_out));
      cmp("oe update", 62'hc3a5, 62'(poe));
      @(posedge clock);
      coe <= ~coe;
      cpo <= ~cpo;
      ctx <= ~ctx;
      repeat (4) @(negedge clock);
      cmp("oe held", 62'hc3a5, 62'(poe));
      cmp("pad data", 62'(cpo), 62'(pout));
      tester.scan(1'b0, 62, mk(5'h0a, 16'h3c5a), d);
      cmp("extest word", exp_cap(1'b1), d & MASK);
      cmp("tx second", 62'h0a, 62'(tx_out));
      cmp("oe second", 62'h3c5a, 62'(poe));
      pop();
   endtask
   task automatic t_highz();
      tester.shift_ir(`BSRC_IR_HIGHZ);
      cmp("oe highz", 62'h0, 62'(poe));
      tester.reset_tap();
      @(negedge clock);
      cmp("oe after reset", 62'(coe), 62'(poe));
      repeat (20) @(posedge clock);
      coe <= 16'h1234;
      ctx <= 5'h13;
      repeat (3) @(negedge clock);
      cmp("oe follows", 62'h1234, 62'(poe));
      cmp("tx follows", 62'h13, 62'(tx_out));
   endtask
   task automatic t_trst();
      tester.shift_ir(`BSRC_IR_EXTEST);
      tester.hold_trst(8);
      @(negedge clock);
      cmp("oe under trst", 62'(coe), 62'(poe));
      cmp("tdo under trst", 62'h0, 62'(tdo_oe));
      repeat (8) @(posedge clock);
   endtask
   task automatic t_fifo();
      int k;
      k = 0;
      tester.reset_tap();
      tester.shift_ir(`BSRC_IR_SAMPLE);
      repeat (17) tester.scan(1'b0, 1, '0, d);
      cmp("fifo ready", 62'h0, 62'(snap_in_ready));
      while (snap_valid === 1'b1 && k < 40) begin
         pop();
         k++;
      end
      cmp("fifo count", 62'd16, 62'(k));
   endtask
   initial begin
      repeat (4) @(posedge clock);
      srst <= 1'b0;
      repeat (6) @(posedge clock);
      t_idcode();
      t_bypass();
      t_sample();
      t_extest();
      t_highz();
      t_trst();
      t_fifo();
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      $display("unexpected run time: expected end seen hang");
      print_verdict();
   end
endmodule
